// ---- core/apc_regs.vh ----
// constants of the architectural event counter block
// assumes: included by bare name from the design files under core/
`ifndef APC_REGS_VH
`define APC_REGS_VH

// register address bases
`define APC_CTR_BASE    32'h000000C1
`define APC_SEL_BASE    32'h00000186

// selector field positions
`define APC_SEL_CODE_LO 0
`define APC_SEL_QUAL_LO 8
`define APC_SEL_USR     16
`define APC_SEL_OS      17
`define APC_SEL_EDGE    18
`define APC_SEL_PC      19
`define APC_SEL_INT     20
`define APC_SEL_EN      22
`define APC_SEL_INV     23
`define APC_SEL_THR_LO  24
`define APC_SEL_WMASK   32'hFFDFFFFF
`define APC_SEL_RST     32'h00000000

// capability word field positions
`define APC_CAP_VER_LO  0
`define APC_CAP_NUM_LO  8
`define APC_CAP_WID_LO  16
`define APC_CAP_EVN_LO  24

// counter write sign bit and reset values
`define APC_WR_SIGN     31
`define APC_CTR_RST     64'h0000000000000000

// per-cycle occurrence count width (popcount of eight lines)
`define APC_OCC_W       4
`define APC_COND_W      8

`endif

// ---- core/apc_event_qual.v ----
// one event qualifier: unit select, condition mask, threshold, edge, level
// assumes: event lines come from logic on clk; one instance per counter
`include "apc_regs.vh"

module apc_event_qual #(
	parameter NUNITS = 8
) (
	// clock and reset
	input  wire                           clk,
	input  wire                           nrst,
	// event units and processor state
	input  wire [NUNITS*`APC_COND_W-1:0]  ev_cond,
	input  wire [1:0]                     cpl,
	// paired selector contents
	input  wire [31:0]                    sel,
	// amount to add to the counter next cycle
	output reg  [`APC_OCC_W-1:0]          inc
);

	reg  [`APC_COND_W-1:0] cond;
	reg  [`APC_OCC_W-1:0]  occ;
	reg                    prev;
	reg                    fires;
	reg                    allow;
	reg  [`APC_OCC_W-1:0]  next_inc;
	wire [7:0]             code = sel[`APC_SEL_CODE_LO +: 8];
	wire [7:0]             qual = sel[`APC_SEL_QUAL_LO +: 8];
	wire [7:0]             thr  = sel[`APC_SEL_THR_LO +: 8];

	// pick the unit, mask its lines, count hits this cycle
	always @* begin : qual_comb
		integer i;
		i = 0;
		cond = {`APC_COND_W{1'b0}};
		occ = {`APC_OCC_W{1'b0}};
		if (code < NUNITS) begin // see R7
			cond = ev_cond[code*`APC_COND_W +: `APC_COND_W];
		end
		for (i = 0; i < `APC_COND_W; i = i + 1) begin
			occ = occ + {{(`APC_OCC_W-1){1'b0}}, cond[i] & qual[i]}; // see R8
		end
		// threshold compare, flip ignored at zero threshold
		if (thr != 8'h00) begin
			fires = ({4'h0, occ} >= thr) ^ sel[`APC_SEL_INV]; // see R18
		end else begin
			fires = (occ != {`APC_OCC_W{1'b0}});
		end
		// privilege filters and enable
		allow = sel[`APC_SEL_EN] & // see R16
			((sel[`APC_SEL_USR] & (cpl != 2'h0)) | // see R10
			(sel[`APC_SEL_OS] & (cpl == 2'h0))); // see R11
		if (!allow) begin
			next_inc = {`APC_OCC_W{1'b0}};
		end else if (sel[`APC_SEL_EDGE]) begin
			next_inc = {{(`APC_OCC_W-1){1'b0}}, fires & ~prev}; // see R12
		end else if (thr != 8'h00) begin
			next_inc = {{(`APC_OCC_W-1){1'b0}}, fires}; // see R19
		end else begin
			next_inc = occ; // see R20
		end
	end

	// previous condition for edge detect, registered amount
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev <= 1'b0;
			inc  <= {`APC_OCC_W{1'b0}};
		end else begin
			prev <= fires;
			inc  <= next_inc;
		end
	end

endmodule

// ---- core/apc_counter_block.v ----
// architectural event counters with their selectors, one logical processor
// assumes: register accesses and event lines are synchronous to clk;
// monitor pins are sampled by a bus running on clk
//
// What this block does
// R1: each logical processor has its own selectors and counters, nothing shared
// R2: capability word bits 7:0 give a version, nonzero means present
// R3: counters sit contiguously from 0C1H; count reported in bits 15:8
// R4: selectors sit contiguously from 186H; selector n drives counter n
// R5: counter width reported in bits 23:16; only those bits read back
// R6: counter writes take low 32 bits, upper bits copy bit 31
// R7: selector bits 7:0 choose the feeding event unit, subset supported
// R8: selector bits 15:8 qualify the condition of the chosen unit
// R9: second capability word is event vector; first gives event count
// R10: bit 16 counts at privilege levels 1, 2 and 3
// R11: bit 17 counts at level 0; both bits count all levels
// R12: bit 18 counts rising transitions only; back-to-back merge
// R13: bit 19 pulses pin per counted event, else only on overflow
// R14: each pin pulse is high for exactly one bus clock
// R15: bit 20 makes overflow raise an interrupt request
// R16: bit 22 enables counting; clear holds the counter
// R17: software clears bit 22 before rewriting the paired counter
// R18: bit 23 flips threshold compare; ignored when threshold is zero
// R19: nonzero threshold adds one in each cycle the compare holds
// R20: zero threshold adds the whole per-cycle occurrence count
// R21: counter wraps all ones to zero at its width; that is overflow
// R22: reset clears selectors and counters; undefined bits read zero
`include "apc_regs.vh"

module apc_counter_block #(
	parameter NCNT     = 4,
	parameter CTR_W    = 40,
	parameter NUNITS   = 8,
	parameter VERSION  = 8'h01,
	parameter NUM_ARCH = 8'h07,
	parameter EVT_VEC  = 32'h00000000
) (
	// clock and reset
	input  wire                          clk,
	input  wire                          nrst,
	// register access port
	input  wire                          msr_rd,
	input  wire                          msr_wr,
	input  wire [31:0]                   msr_addr,
	input  wire [63:0]                   msr_wdata,
	output reg  [63:0]                   msr_rdata,
	output reg                           msr_ack,
	output reg                           msr_fault,
	// capability query
	input  wire                          cap_query,
	output reg  [31:0]                   cap_word0,
	output reg  [31:0]                   cap_word1,
	output reg                           cap_valid,
	// event units and processor state
	input  wire [NUNITS*`APC_COND_W-1:0] ev_cond,
	input  wire [1:0]                    cpl,
	// monitor pins and interrupt requests
	output wire [NCNT-1:0]               monitor_pin,
	output wire [NCNT-1:0]               ovf_irq
);

	// index width for the counter number
	localparam IDX_W = (NCNT > 16) ? 5 : (NCNT > 8) ? 4 :
		(NCNT > 4) ? 3 : (NCNT > 2) ? 2 : 1;
	localparam [63:0] CTR_MASK = {{(64-CTR_W){1'b0}}, {CTR_W{1'b1}}};
	localparam [63:0] CTR_RST  = `APC_CTR_RST;

	// flat views of the per-counter state for the read mux
	wire [NCNT*32-1:0]    sel_flat;
	wire [NCNT*CTR_W-1:0] cnt_flat;

	// address decode results
	wire [IDX_W:0] ctr_dec;
	wire [IDX_W:0] sel_dec;
	wire           ctr_hit = ctr_dec[IDX_W];
	wire           sel_hit = sel_dec[IDX_W];
	wire [IDX_W-1:0] ctr_idx = ctr_dec[IDX_W-1:0];
	wire [IDX_W-1:0] sel_idx = sel_dec[IDX_W-1:0];

	// value loaded into a counter on write, sign-extended from bit 31
	wire [CTR_W-1:0] ctr_load = {{(CTR_W-32){msr_wdata[`APC_WR_SIGN]}},
		msr_wdata[31:0]}; // see R6

	// decode an address against a contiguous block: {hit, index}
	function [IDX_W:0] apc_dec;
		input [31:0] addr;
		input [31:0] base;
		reg   [31:0] off;
		begin
			off = addr - base;
			if (off < NCNT) begin
				apc_dec = {1'b1, off[IDX_W-1:0]};
			end else begin
				apc_dec = {1'b0, {IDX_W{1'b0}}};
			end
		end
	endfunction

	assign ctr_dec = apc_dec(msr_addr, `APC_CTR_BASE); // see R3
	assign sel_dec = apc_dec(msr_addr, `APC_SEL_BASE); // see R4

	// one selector, counter, qualifier, pin and request per counter;
	// this whole set is private to the logical processor it serves
	genvar g;
	generate
		for (g = 0; g < NCNT; g = g + 1) begin : chan
			reg  [31:0]             sel; // see R1
			reg  [CTR_W-1:0]        cnt;
			reg                     pin;
			reg                     irq;
			wire [`APC_OCC_W-1:0]   inc;
			wire [CTR_W:0]          sum;
			wire                    ovf;
			wire                    wr_sel;
			wire                    wr_cnt;
			wire                    pin_req;

			apc_event_qual #(
				.NUNITS (NUNITS)
			) u_qual (
				.clk     (clk),
				.nrst    (nrst),
				.ev_cond (ev_cond),
				.cpl     (cpl),
				.sel     (sel),
				.inc     (inc)
			);

			assign wr_sel = msr_wr & sel_hit & (sel_idx == g);
			assign wr_cnt = msr_wr & ctr_hit & (ctr_idx == g);
			// carry out of the implemented width is the overflow
			assign sum = {1'b0, cnt} +
				{{(CTR_W+1-`APC_OCC_W){1'b0}}, inc};
			assign ovf = sum[CTR_W] & ~wr_cnt; // see R21
			// per-hit pulsing or overflow-only pulsing
			assign pin_req = sel[`APC_SEL_PC] ?
				(inc != {`APC_OCC_W{1'b0}}) & ~wr_cnt : ovf; // see R13

			// selector: writable bits only, bit 21 and upper held zero
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					sel <= `APC_SEL_RST; // see R22
				end else if (wr_sel) begin
					sel <= msr_wdata[31:0] & `APC_SEL_WMASK;
				end
			end

			// counter: a write wins over counting in the same cycle
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					cnt <= CTR_RST[CTR_W-1:0]; // see R22
				end else if (wr_cnt) begin
					cnt <= ctr_load; // see R17
				end else begin
					cnt <= sum[CTR_W-1:0]; // see R21
				end
			end

			// pin high one clock, forced low the next; requests that
			// land on the high clock are merged into that pulse
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					pin <= 1'b0;
					irq <= 1'b0;
				end else begin
					pin <= pin_req & ~pin; // see R14
					irq <= ovf & sel[`APC_SEL_INT]; // see R15
				end
			end

			assign monitor_pin[g] = pin;
			assign ovf_irq[g]     = irq;
			assign sel_flat[g*32 +: 32]       = sel;
			assign cnt_flat[g*CTR_W +: CTR_W] = cnt;
		end
	endgenerate

	// read data selection, answered the cycle after the request
	reg [63:0] next_rdata;
	reg        next_fault;

	always @* begin
		next_rdata = 64'h0000000000000000;
		next_fault = 1'b0;
		if (ctr_hit) begin
			// only the implemented low bits are returned
			next_rdata = {{(64-CTR_W){1'b0}},
				cnt_flat[ctr_idx*CTR_W +: CTR_W]} & CTR_MASK; // see R5
		end else if (sel_hit) begin
			next_rdata = {32'h00000000,
				sel_flat[sel_idx*32 +: 32]}; // see R22
		end else begin
			next_fault = 1'b1;
		end
	end

	// register access answer: ack with data, fault on unmapped address
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			msr_rdata <= 64'h0000000000000000;
			msr_ack   <= 1'b0;
			msr_fault <= 1'b0;
		end else begin
			msr_ack   <= msr_rd | msr_wr;
			msr_fault <= (msr_rd | msr_wr) & next_fault;
			if (msr_rd) begin
				msr_rdata <= next_rdata;
			end
		end
	end

	// capability words, captured on a query and held until the next
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cap_word0 <= 32'h00000000;
			cap_word1 <= 32'h00000000;
			cap_valid <= 1'b0;
		end else begin
			cap_valid <= cap_query;
			if (cap_query) begin
				cap_word0 <= {NUM_ARCH[7:0], // see R9
					CTR_W[7:0], // see R5
					NCNT[7:0], // see R3
					VERSION[7:0]}; // see R2
				cap_word1 <= EVT_VEC; // see R9
			end
		end
	end

endmodule

// ---- testbench/apc_counter_block_properties.sv ----
// checker for the event counter block: access port, capability, pins
// assumes: bound to apc_counter_block, everything on clk
module apc_cb_props #(
	parameter NCNT   = 4,
	parameter CTR_W  = 40,
	parameter NUNITS = 8
) (
	// clock and reset
	input logic                  clk,
	input logic                  nrst,
	// register access port
	input logic                  msr_rd,
	input logic                  msr_wr,
	input logic [31:0]           msr_addr,
	input logic [63:0]           msr_wdata,
	input logic [63:0]           msr_rdata,
	input logic                  msr_ack,
	input logic                  msr_fault,
	// capability query
	input logic                  cap_query,
	input logic [31:0]           cap_word0,
	input logic [31:0]           cap_word1,
	input logic                  cap_valid,
	// events, pins, requests
	input logic [NUNITS*8-1:0]   ev_cond,
	input logic [1:0]            cpl,
	input logic [NCNT-1:0]       monitor_pin,
	input logic [NCNT-1:0]       ovf_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// reads that land on counters or selectors
	wire ctr_rd = msr_rd && (msr_addr - 32'h000000C1) < NCNT;
	wire sel_rd = msr_rd && (msr_addr - 32'h00000186) < NCNT;
	sequence s_req;
		msr_rd || msr_wr;
	endsequence
	sequence s_cap_answer;
		cap_valid && cap_word0[15:8] == NCNT && cap_word0[23:16] == CTR_W;
	endsequence
	AST_ACK: assert property (s_req |=> msr_ack)
		else $error("access without answer");
	AST_NO_ACK: assert property (!(msr_rd || msr_wr) |=> !msr_ack && !msr_fault)
		else $error("answer without access");
	AST_MAPPED: assert property (ctr_rd || sel_rd |=> !msr_fault)
		else $error("mapped register refused");
	AST_UNMAPPED: assert property (msr_rd && msr_addr == 32'h00000200
		|=> msr_fault && msr_rdata == 64'h0)
		else $error("unmapped read not refused");
	AST_CTR_WIDTH: assert property (ctr_rd |=> msr_rdata[63:CTR_W] == 0)
		else $error("counter bits above width set");
	AST_SEL_ZERO: assert property (sel_rd
		|=> msr_rdata[63:32] == 32'h0 && !msr_rdata[21])
		else $error("undefined selector bits set");
	AST_CAP: assert property (cap_query |=> s_cap_answer)
		else $error("capability fields wrong");
	AST_VER: assert property (cap_query |=> cap_word0[7:0] != 8'h00)
		else $error("version zero");
	AST_PIN: assert property ((monitor_pin & $past(monitor_pin)) == 0)
		else $error("pin high two cycles");
endmodule

// ---- testbench/apc_sw_model.sv ----
// software side: register reads and writes over the access port
// assumes: answer comes exactly one clock after the request edge
module apc_sw_model (
	input  logic        clk,
	input  logic [63:0] msr_rdata,
	output logic        msr_rd,
	output logic        msr_wr,
	output logic [31:0] msr_addr,
	output logic [63:0] msr_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial {msr_rd, msr_wr, msr_addr, msr_wdata} = '0;
	// one access: request for one edge, answer taken at the next
	task acc(input logic w, input logic [31:0] a, input logic [63:0] d,
		output logic [63:0] q);
		@(posedge clk);
		msr_wr <= w;
		msr_rd <= !w;
		msr_addr <= a;
		msr_wdata <= d;
		@(posedge clk);
		msr_wr <= 1'b0;
		msr_rd <= 1'b0;
		msr_wdata <= ~d; // released data shows no stale value
		@(posedge clk);
		q = msr_rdata;
	endtask
endmodule

// ---- testbench/apc_counter_block_tb.sv ----
// self-checking bench for the event counter block
// assumes: design under core/ and the other bench files compiled first
module apc_counter_block_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, cap_query, msr_rd, msr_wr, msr_ack, msr_fault;
	logic        cap_valid;
	logic [1:0]  cpl;
	logic [31:0] msr_addr, cap_word0, cap_word1;
	logic [63:0] msr_wdata, msr_rdata, ev_cond, q;
	logic [3:0]  monitor_pin, ovf_irq;
	int          failures, num_checks, pins, irqs;
	apc_counter_block dut (.clk(clk), .nrst(nrst), .msr_rd(msr_rd),
		.msr_wr(msr_wr), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
		.msr_rdata(msr_rdata), .msr_ack(msr_ack), .msr_fault(msr_fault),
		.cap_query(cap_query), .cap_word0(cap_word0), .cap_word1(cap_word1),
		.cap_valid(cap_valid), .ev_cond(ev_cond), .cpl(cpl),
		.monitor_pin(monitor_pin), .ovf_irq(ovf_irq));
	apc_sw_model sw (.clk(clk), .msr_rdata(msr_rdata), .msr_rd(msr_rd),
		.msr_wr(msr_wr), .msr_addr(msr_addr), .msr_wdata(msr_wdata));
	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// tally overflow requests and pin pulses of counter 0
	always @(posedge clk) begin
		irqs += ovf_irq[0];
		pins += monitor_pin[0];
	end
	task chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [31:0] a, input logic [63:0] d);
		sw.acc(1'b1, a, d, q);
	endtask
	task rd_chk(input logic [31:0] a, input logic [63:0] e);
		sw.acc(1'b0, a, 64'h0, q);
		chk(q, e);
	endtask
	// disable, load counter, then program selector
	task setc(input int n, input logic [63:0] v, input logic [31:0] s);
		wr(32'h186 + n, 64'h0);
		wr(32'hC1 + n, v);
		wr(32'h186 + n, {32'h0, s});
	endtask
	task ev(input logic [7:0] p, input int n, input logic [1:0] c);
		@(posedge clk);
		ev_cond <= {56'h0, p};
		cpl <= c;
		repeat (n) @(posedge clk);
		ev_cond <= 64'h0;
		repeat (3) @(posedge clk);
	endtask
	task t_reset;
		rd_chk(32'h186, 64'h0);
		rd_chk(32'hC4, 64'h0);
		@(posedge clk);
		cap_query <= 1'b1;
		@(posedge clk);
		cap_query <= 1'b0;
		@(posedge clk);
		chk({cap_word1, cap_word0}, 64'h07280401);
		$display("reset and capability done");
	endtask
	task t_regs;
		wr(32'h189, 64'hFFFFFFFFFFFFFFFF);
		rd_chk(32'h189, 64'hFFDFFFFF);
		wr(32'h189, 64'h0);
		setc(1, 64'h80000005, 32'h0);
		rd_chk(32'hC2, 64'hFF80000005);
		setc(2, 64'hABCD7FFFFFFF, 32'h0);
		rd_chk(32'hC3, 64'h7FFFFFFF);
		rd_chk(32'h200, 64'h0);
		rd_chk(32'h18A, 64'h0);
		$display("register access done");
	endtask
	task t_count;
		setc(0, 64'h0, 32'h00430100);
		ev(8'h01, 3, 2'h3);
		ev(8'h02, 2, 2'h3);
		rd_chk(32'hC1, 64'h3);
		setc(0, 64'h0, 32'h00430101);
		ev(8'h01, 2, 2'h3);
		rd_chk(32'hC1, 64'h0);
		setc(0, 64'h0, 32'h00C3FF00);
		ev(8'h07, 2, 2'h3);
		rd_chk(32'hC1, 64'h6);
		setc(0, 64'h0, 32'h0243FF00);
		ev(8'h07, 2, 2'h3);
		ev(8'h01, 2, 2'h3);
		rd_chk(32'hC1, 64'h2);
		setc(0, 64'h0, 32'h00470100);
		ev(8'h01, 4, 2'h3);
		ev(8'h01, 1, 2'h3);
		rd_chk(32'hC1, 64'h2);
		wr(32'h186, 64'h00030100);
		ev(8'h01, 2, 2'h3);
		rd_chk(32'hC1, 64'h2);
		setc(0, 64'h0, 32'h00410100);
		ev(8'h01, 2, 2'h0);
		ev(8'h01, 3, 2'h2);
		rd_chk(32'hC1, 64'h3);
		setc(0, 64'h0, 32'h00420100);
		ev(8'h01, 2, 2'h2);
		ev(8'h01, 1, 2'h0);
		rd_chk(32'hC1, 64'h1);
		$display("counting done");
	endtask
	task t_ovf;
		setc(0, 64'hFFFFFFFF, 32'h00530100);
		irqs = 0;
		pins = 0;
		ev(8'h01, 1, 2'h3);
		rd_chk(32'hC1, 64'h0);
		chk({irqs, pins}, {32'h1, 32'h1});
		setc(0, 64'h0, 32'h004B0100);
		pins = 0;
		ev(8'h01, 1, 2'h3);
		ev(8'h01, 1, 2'h3);
		rd_chk(32'hC1, 64'h2);
		chk(pins, 64'h2);
		$display("overflow and pins done");
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_of_test;
	end
	// main sequence
	initial begin
		{nrst, cap_query, failures, num_checks} = '0;
		ev_cond = 64'h0;
		cpl = 2'h3;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset;
		t_regs;
		t_count;
		t_ovf;
		end_of_test;
	end
endmodule
bind apc_counter_block apc_cb_props #(.NCNT(NCNT), .CTR_W(CTR_W),
	.NUNITS(NUNITS)) u_props (.clk(clk), .nrst(nrst), .msr_rd(msr_rd),
	.msr_wr(msr_wr), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
	.msr_rdata(msr_rdata), .msr_ack(msr_ack), .msr_fault(msr_fault),
	.cap_query(cap_query), .cap_word0(cap_word0), .cap_word1(cap_word1),
	.cap_valid(cap_valid), .ev_cond(ev_cond), .cpl(cpl),
	.monitor_pin(monitor_pin), .ovf_irq(ovf_irq));
